/* logic/fcp_pkg.sv */
// Constants, register map and carrier types of the four-channel pwm unit
//
// Contract
// R1: Channel runs only while its enable bit (bits 0,1,4,5) is set.
// R2: Channel waveform reaches its pin only while its drive bit (2,3,6,7) is set.
// R3: Each channel has a readable 8-bit duty register; channels 2 and 3 at ddh, deh.
// R4: A new duty value takes effect at once, not at period end.
// R5: Duty 00h holds the pin high, duty ffh holds it low.
// R6: Shared counter counts modulo 255, never reaching ffh.
// R7: Within each period the pin is low for duty counts, high for 255 minus duty.
// R8: Counter steps once per 2 x (prescale + 1) oscillator clocks.
// R9: Reset clears every enable and drive bit.
package fcp_pkg;

    localparam int unsigned FCP_CHANNELS = 4;

    // Special function register addresses
    localparam logic [7:0] FCP_ADDR_PRESCALE = 8'hd9;
    localparam logic [7:0] FCP_ADDR_DUTY0 = 8'hda;
    localparam logic [7:0] FCP_ADDR_DUTY1 = 8'hdb;
    localparam logic [7:0] FCP_ADDR_CONTROL = 8'hdc;
    localparam logic [7:0] FCP_ADDR_DUTY2 = 8'hdd;
    localparam logic [7:0] FCP_ADDR_DUTY3 = 8'hde;

    // Control register field positions, per channel
    localparam int unsigned FCP_RUN_BIT [FCP_CHANNELS] = '{0, 1, 4, 5};
    localparam int unsigned FCP_DRIVE_BIT [FCP_CHANNELS] = '{2, 3, 6, 7};

    // Values after reset
    localparam logic [7:0] FCP_CONTROL_RESET = 8'h00;
    localparam logic [7:0] FCP_DUTY_RESET = 8'h00;
    localparam logic [7:0] FCP_PRESCALE_RESET = 8'h00;
    localparam logic [7:0] FCP_COUNT_RESET = 8'h00;

    // Counter wraps after this value, so it never reaches ffh
    localparam logic [7:0] FCP_COUNT_LAST = 8'hfe;
    // Read value of an address this unit does not own
    localparam logic [7:0] FCP_UNMAPPED_READ = 8'hff;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } fcp_sfr_req_type;

    typedef struct packed {
        logic hit;
        logic [7:0] rdata;
    } fcp_sfr_rsp_type;

endpackage

/* logic/fcp_pwm_unit.sv */
// Four-channel 8-bit pwm unit with its special function registers
`timescale 1ns/1ps
`default_nettype none
module fcp_pwm_unit
    import fcp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire fcp_sfr_req_type sfr_req,
    output fcp_sfr_rsp_type sfr_rsp,
    output logic [FCP_CHANNELS-1:0] pwm_out,
    output logic [FCP_CHANNELS-1:0] pwm_oe
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] control_q;
    logic [7:0] control_d;
    logic [7:0] prescale_q;
    logic [7:0] prescale_d;
    logic [7:0] duty_q [FCP_CHANNELS];
    logic [7:0] duty_d [FCP_CHANNELS];
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic step;
    logic [FCP_CHANNELS-1:0] run;
    logic [FCP_CHANNELS-1:0] drive;
    logic [FCP_CHANNELS-1:0] out_d;
    logic [FCP_CHANNELS-1:0] oe_d;

    always_comb begin
        control_d = control_q;
        prescale_d = prescale_q;
        for (int i = 0; i < FCP_CHANNELS; i++) begin
            duty_d[i] = duty_q[i];
        end
        if (sfr_req.wr) begin
            unique case (sfr_req.addr)
                FCP_ADDR_CONTROL: control_d = sfr_req.wdata; // R1 R2
                FCP_ADDR_PRESCALE: prescale_d = sfr_req.wdata; // R8
                FCP_ADDR_DUTY0: duty_d[0] = sfr_req.wdata; // R3
                FCP_ADDR_DUTY1: duty_d[1] = sfr_req.wdata; // R3
                FCP_ADDR_DUTY2: duty_d[2] = sfr_req.wdata; // R3
                FCP_ADDR_DUTY3: duty_d[3] = sfr_req.wdata; // R3
                default: ;
            endcase
        end
    end

    // Reads are combinational so the cpu sees the value in the same cycle
    always_comb begin
        sfr_rsp.hit = 1'b1;
        unique case (sfr_req.addr)
            FCP_ADDR_CONTROL: sfr_rsp.rdata = control_q;
            FCP_ADDR_PRESCALE: sfr_rsp.rdata = prescale_q;
            FCP_ADDR_DUTY0: sfr_rsp.rdata = duty_q[0]; // R3
            FCP_ADDR_DUTY1: sfr_rsp.rdata = duty_q[1]; // R3
            FCP_ADDR_DUTY2: sfr_rsp.rdata = duty_q[2]; // R3
            FCP_ADDR_DUTY3: sfr_rsp.rdata = duty_q[3]; // R3
            default: begin
                sfr_rsp.hit = 1'b0;
                sfr_rsp.rdata = FCP_UNMAPPED_READ;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control_q <= FCP_CONTROL_RESET; // R9
            prescale_q <= FCP_PRESCALE_RESET;
            for (int i = 0; i < FCP_CHANNELS; i++) begin
                duty_q[i] <= FCP_DUTY_RESET;
            end
        end else begin
            control_q <= control_d;
            prescale_q <= prescale_d;
            for (int i = 0; i < FCP_CHANNELS; i++) begin
                duty_q[i] <= duty_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared timebase

    fcp_step_divider u_divider (
        .sys_clk(sys_clk),
        .rst(rst),
        .prescale(prescale_q),
        .step(step)
    );

    // Free running even with all channels off, so channels share one phase
    always_comb begin
        count_d = count_q;
        if (step) begin
            count_d = (count_q == FCP_COUNT_LAST) ? FCP_COUNT_RESET : count_q + 8'h01; // R6
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_q <= FCP_COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channels

    for (genvar ch = 0; ch < FCP_CHANNELS; ch++) begin : g_chan
        assign run[ch] = control_q[FCP_RUN_BIT[ch]];
        assign drive[ch] = control_q[FCP_DRIVE_BIT[ch]];
        // Live duty compare: a write shows on the next edge, mid period included
        // Pin is low for duty counts and high for the rest; ffh never matches
        always_comb begin
            out_d[ch] = run[ch] & drive[ch] & (count_q >= duty_q[ch]); // R1 R4 R5 R7
            oe_d[ch] = drive[ch]; // R2
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwm_out <= '0;
            pwm_oe <= '0; // R9
        end else begin
            pwm_out <= out_d;
            pwm_oe <= oe_d;
        end
    end

endmodule
`default_nettype wire

/* logic/fcp_step_divider.sv */
// Prescale divider: one-cycle step pulse every 2 x (prescale + 1) clocks
`timescale 1ns/1ps
`default_nettype none
module fcp_step_divider
    import fcp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] prescale,
    output logic step
);

    logic [7:0] div_q;
    logic [7:0] div_d;
    logic half_q;
    logic half_d;
    logic step_d;

    // Compare against the live prescale so a new value applies in the running interval
    always_comb begin
        div_d = div_q + 8'h01;
        half_d = half_q;
        step_d = 1'b0;
        if (div_q >= prescale) begin // R8
            div_d = 8'h00;
            half_d = ~half_q;
            step_d = half_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_q <= 8'h00;
            half_q <= 1'b0;
            step <= 1'b0;
        end else begin
            div_q <= div_d;
            half_q <= half_d;
            step <= step_d;
        end
    end

endmodule
`default_nettype wire

/* verification/fcp_motor_load.sv */
// Motor load on the pins, counting channel 0 high time
`timescale 1ns/1ps
`default_nettype none
module fcp_motor_load (
    input wire logic sys_clk,
    input wire logic clr,
    input wire logic [3:0] pwm_out,
    input wire logic [3:0] pwm_oe,
    output logic [15:0] hi0,
    output logic [7:0] rise0
);
    logic pin0;
    logic last0;
    // Undriven pins sit at the pull-down level
    assign pin0 = pwm_out[0] & pwm_oe[0];
    always @(posedge sys_clk) hi0 <= clr ? 16'h0 : hi0 + {15'h0, pin0};
    // Rising edges per window tell one period from two shorter ones
    always @(posedge sys_clk) begin
        last0 <= pin0;
        rise0 <= clr ? 8'h00 : rise0 + {7'h00, pin0 & ~last0};
    end
endmodule
`default_nettype wire

/* verification/fcp_pwm_unit_properties.sv */
// Port checker for the pwm unit
`timescale 1ns/1ps
`default_nettype none
module fcp_pwm_checker
    import fcp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire fcp_sfr_req_type sfr_req,
    input wire fcp_sfr_rsp_type sfr_rsp,
    input wire logic [FCP_CHANNELS-1:0] pwm_out,
    input wire logic [FCP_CHANNELS-1:0] pwm_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic m;
    logic cw;
    logic [7:0] w;
    logic [7:0] ctl;
    assign m = sfr_req.addr inside {[8'hd9:8'hde]};
    assign cw = sfr_req.wr && sfr_req.addr == 8'hdc;
    assign w = sfr_req.wdata;
    // Shadow of the control register, rebuilt from the bus writes alone
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl <= 8'h00;
        end else if (cw) begin
            ctl <= w;
        end
    end
    a_reset_clear:
    assert property ($fell(rst) |-> {pwm_oe, pwm_out} == 8'h00) else $error("reset");
    a_drive_bits:
    assert property (cw |-> ##2 pwm_oe == {$past(w[7:6], 2), $past(w[3:2], 2)}) else $error("oe");
    a_drive_cause:
    assert property ($changed(pwm_oe) |-> $past(cw, 2)) else $error("oe cause");
    a_read_back:
    assert property (sfr_req.wr && m ##1 sfr_req.addr == $past(sfr_req.addr)
        |-> sfr_rsp.rdata == $past(w)) else $error("readback");
    a_unmapped_read:
    assert property (!m |-> !sfr_rsp.hit && sfr_rsp.rdata == 8'hff) else $error("unmapped");
    a_hit_map:
    assert property (m |-> sfr_rsp.hit) else $error("hit");
    a_out_gated:
    assert property ((pwm_out & ~pwm_oe) == 4'h0) else $error("gated");
    a_run_gate:
    assert property ((pwm_out & ~$past({ctl[5:4], ctl[1:0]})) == 4'h0) else $error("run");
    a_full_low:
    assert property (sfr_req.wr && sfr_req.addr == 8'hdd && w == 8'hff |-> ##2 !pwm_out[2])
        else $error("ffh");
    cover property (cw);
    cover property ($rose(pwm_out[0]));
    cover property (!m && sfr_req.addr != 8'h00);
endmodule
bind fcp_pwm_unit fcp_pwm_checker fcp_pwm_checker_i (.sys_clk(sys_clk), .rst(rst),
    .sfr_req(sfr_req), .sfr_rsp(sfr_rsp), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the pwm unit
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench
    import fcp_pkg::*;
;
    logic sys_clk = 1'b0, rst = 1'b1, probe = 1'b0, sel = 1'b0, clr = 1'b1;
    fcp_sfr_req_type sfr_req = '0;
    fcp_sfr_rsp_type sfr_rsp;
    logic [3:0] pwm_out, pwm_oe;
    logic [15:0] hi0, rnd = 16'hc92f;
    logic [7:0] rise0, duty0, exp_v;
    logic [7:0] q[$];
    logic [7:0] da[4] = '{8'hda, 8'hdb, 8'hdd, 8'hde};
    int num_errors = 0, compares = 0;
    always #12.5 sys_clk = ~sys_clk;
    fcp_pwm_unit fcp_pwm_unit_i (.sys_clk(sys_clk), .rst(rst), .sfr_req(sfr_req),
        .sfr_rsp(sfr_rsp), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
    fcp_motor_load fcp_motor_load_i (.sys_clk(sys_clk), .clr(clr), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe), .hi0(hi0), .rise0(rise0));
    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        sfr_req = '{addr: a, wr: 1'b1, wdata: v};
        @(negedge sys_clk);
        sfr_req.wr = 1'b0;
    endtask
    // Expected value is queued; the monitor compares it at the next edge
    task automatic chk(input logic [7:0] a, input logic s, input logic [7:0] x);
        @(negedge sys_clk);
        sfr_req.addr = a;
        sel = s;
        q.push_back(x);
        probe = 1'b1;
        @(negedge sys_clk);
        probe = 1'b0;
    endtask
    // Pop once into a variable: the macro names its expected value twice
    always @(posedge sys_clk) begin
        if (probe) begin
            exp_v = q.pop_front();
            `CMP(sel ? {pwm_oe, pwm_out} : sfr_rsp.rdata, exp_v)
            if (!sel) `CMP(sfr_rsp.hit, sfr_req.addr inside {[8'hd9:8'hde]})
        end
    end
    task automatic results();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        chk(8'hdc, 1'b0, 8'h00);
        chk(8'h00, 1'b1, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wr(8'hd9 + 8'(i), rnd[7:0]);
            chk(8'hd9 + 8'(i), 1'b0, rnd[7:0]);
        end
        chk(8'hd8, 1'b0, 8'hff);
        $display("test registers done");
        wr(8'hdc, 8'hcc);
        for (int i = 0; i < 4; i++) wr(da[i], 8'h00);
        chk(8'h00, 1'b1, 8'hf0);
        wr(8'hdc, 8'hff);
        chk(8'h00, 1'b1, 8'hff);
        wr(8'hdd, 8'hff);
        chk(8'h00, 1'b1, 8'hfb);
        wr(8'hdc, 8'h33);
        chk(8'h00, 1'b1, 8'h00);
        $display("test pins done");
        rnd = lfsr(rnd);
        // Keep duty off 00h and ffh so the window holds exactly one rising edge
        duty0 = {1'b0, rnd[14:8]} | 8'h01;
        wr(8'hd9, 8'h01);
        wr(8'hdc, 8'hff);
        wr(8'hda, duty0);
        repeat (8) @(negedge sys_clk);
        clr = 1'b0;
        // One full period at prescale 1 is 1020 clocks
        repeat (1020) @(negedge sys_clk);
        `CMP(hi0, (16'h00ff - {8'h00, duty0}) * 16'h0004)
        `CMP(rise0, 8'h01)
        $display("test period done");
        results();
    end
    initial begin
        #(25 * 4000);
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
